// File: break_channel.v
// One bus comparator channel: AND of its enabled conditions
`include "break_unit_map.vh"
module break_channel #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire [AW-1:0] i_cmp_addr,
  input wire [DW-1:0] i_cmp_data,
  input wire [7:0] i_cond,
  input wire i_bus_valid,
  input wire [AW-1:0] i_bus_addr,
  input wire [DW-1:0] i_bus_data,
  input wire i_bus_read,
  input wire [1:0] i_bus_type,
  input wire i_retire_valid,
  input wire [AW-1:0] i_retire_pc,
  output wire o_match
);
  // One two-bit mode field makes address and PC exclusive
  wire [1:0] amode = i_cond[`COND_AMODE_LSB+1:`COND_AMODE_LSB];
  wire data_en = i_cond[`COND_DATA_EN];
  wire rw_en = i_cond[`COND_RW_EN];
  wire type_en = i_cond[`COND_TYPE_EN];
  wire [1:0] type_val = i_cond[`COND_TYPE_LSB+1:`COND_TYPE_LSB];
  wire after = (amode == `AMODE_PC_AFTER);
  wire addr_eq = (i_bus_addr == i_cmp_addr);
  reg addr_ok;

  always @* begin
    case (amode)
      `AMODE_NONE: addr_ok = 1'b1;
      `AMODE_ADDR: addr_ok = addr_eq;
      `AMODE_PC_BEFORE: addr_ok = addr_eq && (i_bus_type == `TYPE_FETCH);
      `AMODE_PC_AFTER: addr_ok = (i_retire_pc == i_cmp_addr);
      default: addr_ok = 1'b0;
    endcase
  end

  // After-execution matches on retirement, so bus-cycle terms do not apply there
  wire cyc_ok = after ? i_retire_valid : i_bus_valid;
  wire data_ok = after || !data_en || (i_bus_data == i_cmp_data);
  wire rw_ok = after || !rw_en || (i_bus_read == i_cond[`COND_RW_VAL]);
  wire type_ok = after || !type_en || (type_val == `TYPE_ALL) || (type_val == i_bus_type);
  wire any_en = (amode != `AMODE_NONE) || data_en || rw_en || type_en;

  assign o_match = any_en && cyc_ok && addr_ok && data_ok && rw_ok && type_ok;
endmodule // break_channel

// File: break_unit_map.vh
// Register offsets, field positions and reset values of the bus break unit
`ifndef BREAK_UNIT_MAP_VH
`define BREAK_UNIT_MAP_VH

// Byte offsets of the register map
`define REG_CTRL 8'h00
`define REG_COUNT 8'h50
`define REG_RST_ADDR 8'h54
`define REG_SEQA_CFG 8'h60
`define REG_SEQA_STAT 8'h64
`define REG_SEQB_CFG 8'h68
`define REG_SEQB_STAT 8'h6c
`define REG_STATUS 8'h70
`define REG_MASK 8'h74
// Channel n (0..3) sits at (n+1)*0x10: +0 address, +4 data, +8 condition
`define CH_FIRST 4'h1
`define CH_LAST 4'h4
`define CH_ADDR 2'h0
`define CH_DATA 2'h1
`define CH_COND 2'h2

// Control register fields
`define CTRL_DIRECT_LSB 0
`define CTRL_SEQA_EN 4
`define CTRL_SEQB_EN 5
`define CTRL_RSTA_EN 6
`define CTRL_RSTB_EN 7
`define CTRL_W 9

// Channel condition fields
`define COND_AMODE_LSB 0
`define COND_DATA_EN 2
`define COND_RW_EN 3
`define COND_RW_VAL 4
`define COND_TYPE_EN 5
`define COND_TYPE_LSB 6
`define COND_W 8

// Address modes
`define AMODE_NONE 2'h0
`define AMODE_ADDR 2'h1
`define AMODE_PC_BEFORE 2'h2
`define AMODE_PC_AFTER 2'h3

// Bus cycle types; the ALL code matches every cycle, fetches included
`define TYPE_FETCH 2'h0
`define TYPE_DATA 2'h1
`define TYPE_OTHER 2'h2
`define TYPE_ALL 2'h3

// Sequence configuration: [2:0] point count, point k channel at 4+2k
`define SEQ_NUM_LSB 0
`define SEQ_SEL_LSB 4
`define SEQ_MAX_POINTS 7
`define SEQ_CFG_W 18

// Status / mask bits: [3:0] direct channel breaks, 4 set A, 5 set B
`define ST_SEQA 4
`define ST_SEQB 5
`define ST_W 6

`define CNT_W 16
`define RST_CTRL 9'h000
`define RST_COND 8'h00
`define RST_SEQ 18'h00000
`define RST_MASK 6'h00
`endif

// File: bus_break_checker.sv
// Port-level assertions for the bus break unit
module bus_break_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_bus_valid,
  input wire logic i_retire_valid,
  input wire logic o_break_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  wire req_any = i_avs_read | i_avs_write;

  idle_no_wait_a: assert property (!req_any |-> !o_avs_waitrequest)
    else $error("waitrequest high with no access");
  first_wait_a: assert property ($rose(req_any) |-> o_avs_waitrequest)
    else $error("no wait cycle at start of access");
  one_wait_a: assert property (req_any && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("access waited more than one cycle");
  rdata_hold_a: assert property (!$past(i_avs_read) |-> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  idle_no_break_a: assert property (
    !$past(i_bus_valid) && !$past(i_retire_valid) |-> !o_break_req)
    else $error("break request without bus activity");
  irq_rise_a: assert property ($rose(o_irq) |-> o_break_req || $past(i_avs_write))
    else $error("interrupt rose without break or write");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(i_avs_write))
    else $error("interrupt fell without a write");
  rst_quiet_a: assert property (!$past(i_reset_n) |-> !o_break_req && !o_irq)
    else $error("break or interrupt right after reset");
endmodule // bus_break_checker

bind bus_break_comparator_sequencer bus_break_checker u_chk (
  .i_ref_clk(i_ref_clk),
  .i_reset_n(i_reset_n),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .i_bus_valid(i_bus_valid),
  .i_retire_valid(i_retire_valid),
  .o_break_req(o_break_req),
  .o_irq(o_irq)
);

// File: bus_break_comparator_sequencer.v
// Bus break comparators, first-channel counter, two sequential sets, register slave
//
// Implementation choices: the Avalon-MM register port and the address map.
`include "break_unit_map.vh"
module bus_break_comparator_sequencer #(
  parameter AW = 32,
  parameter DW = 32,
  parameter NCH = 4
) (
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_bus_valid,
  input wire [AW-1:0] i_bus_addr,
  input wire [DW-1:0] i_bus_data,
  input wire i_bus_read,
  input wire [1:0] i_bus_type,
  input wire i_retire_valid,
  input wire [AW-1:0] i_retire_pc,
  output wire o_break_req,
  output wire o_irq
);
  // Byte-enable merge for register writes
  function [31:0] merge_be;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer b;
    begin
      merge_be = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge_be[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // Sequence point select field of point k
  function [1:0] point_sel;
    input [`SEQ_CFG_W-1:0] cfg;
    input [2:0] k;
    begin
      point_sel = cfg[`SEQ_SEL_LSB + 2*k +: 2];
    end
  endfunction

  // Progress word of one set: points configured above points passed
  function [31:0] seq_stat;
    input [2:0] num;
    input [2:0] pos;
    begin
      seq_stat = {25'h0000000, num, 1'b0, pos};
    end
  endfunction

  // ---------------- Avalon slave timing ----------------
  // Every access stalls one cycle, so read data can come from a flop
  reg ack_ff;
  reg [31:0] rdata_ff;
  wire req = i_avs_read || i_avs_write;
  wire wr_go = i_avs_write && ack_ff;
  assign o_avs_waitrequest = req && !ack_ff;
  assign o_avs_readdata = rdata_ff;

  wire [3:0] a_hi = i_avs_address[7:4];
  wire [1:0] a_fld = i_avs_address[3:2];
  wire a_ch = (a_hi >= `CH_FIRST) && (a_hi <= `CH_LAST) && (i_avs_address[1:0] == 2'h0);
  wire [1:0] a_chn = a_hi[1:0] - 2'h1;

  // ---------------- Registers ----------------
  reg [`CTRL_W-1:0] ctrl_ff;
  reg [AW-1:0] ch_addr_ff [0:NCH-1];
  reg [DW-1:0] ch_data_ff [0:NCH-1];
  reg [`COND_W-1:0] ch_cond_ff [0:NCH-1];
  reg [`CNT_W-1:0] cnt_target_ff;
  reg [`CNT_W-1:0] cnt_ff;
  reg [AW-1:0] rst_addr_ff;
  reg [`SEQ_CFG_W-1:0] seqa_cfg_ff;
  reg [`SEQ_CFG_W-1:0] seqb_cfg_ff;
  reg [2:0] seqa_pos_ff;
  reg [2:0] seqb_pos_ff;
  reg [`ST_W-1:0] status_ff;
  reg [`ST_W-1:0] mask_ff;
  reg break_ff;

  // Write merges; only the low bits that each register really has are kept
  wire [31:0] ctrl_wr;
  wire [31:0] cnt_wr;
  wire [31:0] seqa_wr;
  wire [31:0] seqb_wr;
  assign ctrl_wr = merge_be({23'h000000, ctrl_ff}, i_avs_writedata, i_avs_byteenable);
  assign cnt_wr = merge_be({16'h0000, cnt_target_ff}, i_avs_writedata, i_avs_byteenable);
  assign seqa_wr = merge_be({14'h0000, seqa_cfg_ff}, i_avs_writedata, i_avs_byteenable);
  assign seqb_wr = merge_be({14'h0000, seqb_cfg_ff}, i_avs_writedata, i_avs_byteenable);

  // ---------------- Comparator channels ----------------
  wire [NCH-1:0] raw_match;
  wire rst_match;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      break_channel #(.AW(AW), .DW(DW)) u_ch (
        .i_cmp_addr(ch_addr_ff[g]),
        .i_cmp_data(ch_data_ff[g]),
        .i_cond(ch_cond_ff[g]),
        .i_bus_valid(i_bus_valid),
        .i_bus_addr(i_bus_addr),
        .i_bus_data(i_bus_data),
        .i_bus_read(i_bus_read),
        .i_bus_type(i_bus_type),
        .i_retire_valid(i_retire_valid),
        .i_retire_pc(i_retire_pc),
        .o_match(raw_match[g])
      );
    end
  endgenerate

  // Reset point: address condition only, other terms tied off
  wire rst_used = ctrl_ff[`CTRL_RSTA_EN] || ctrl_ff[`CTRL_RSTB_EN];
  break_channel #(.AW(AW), .DW(DW)) u_rst_ch (
    .i_cmp_addr(rst_addr_ff),
    .i_cmp_data({DW{1'b0}}),
    .i_cond({6'h00, (rst_used ? `AMODE_ADDR : `AMODE_NONE)}),
    .i_bus_valid(i_bus_valid),
    .i_bus_addr(i_bus_addr),
    .i_bus_data(i_bus_data),
    .i_bus_read(i_bus_read),
    .i_bus_type(i_bus_type),
    .i_retire_valid(i_retire_valid),
    .i_retire_pc(i_retire_pc),
    .o_match(rst_match)
  );

  // ---------------- Satisfaction count on the first channel ----------------
  // A target of zero means no count condition
  // The count runs on raw matches, whether or not channel one breaks directly
  wire cnt_used = (cnt_target_ff != {`CNT_W{1'b0}});
  wire cnt_hit = raw_match[0] && (cnt_ff + 16'h0001 == cnt_target_ff);
  wire [NCH-1:0] ch_match = {raw_match[NCH-1:1], cnt_used ? cnt_hit : raw_match[0]};
  reg [`CNT_W-1:0] nxt_cnt;
  always @* begin
    nxt_cnt = cnt_ff;
    if (!cnt_used || cnt_hit) begin
      nxt_cnt = {`CNT_W{1'b0}};
    end else if (raw_match[0]) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  // ---------------- Sequential sets ----------------
  wire [2:0] seqa_num = seqa_cfg_ff[`SEQ_NUM_LSB +: 3];
  wire [2:0] seqb_num = seqb_cfg_ff[`SEQ_NUM_LSB +: 3];
  wire seqa_hit = ch_match[point_sel(seqa_cfg_ff, seqa_pos_ff)];
  wire seqb_hit = ch_match[point_sel(seqb_cfg_ff, seqb_pos_ff)];
  wire seqa_on = ctrl_ff[`CTRL_SEQA_EN] && (seqa_num != 3'h0);
  wire seqb_on = ctrl_ff[`CTRL_SEQB_EN] && (seqb_num != 3'h0);
  wire rsta = rst_match && ctrl_ff[`CTRL_RSTA_EN];
  wire rstb = rst_match && ctrl_ff[`CTRL_RSTB_EN];
  // A shortened point count can leave the position past the end; restart the set then
  wire seqa_past = (seqa_pos_ff >= seqa_num);
  wire seqb_past = (seqb_pos_ff >= seqb_num);
  // Reset point beats an advance in the same cycle
  wire seqa_brk = seqa_on && !rsta && seqa_hit && (seqa_pos_ff + 3'h1 == seqa_num);
  wire seqb_brk = seqb_on && !rstb && seqb_hit && (seqb_pos_ff + 3'h1 == seqb_num);
  reg [2:0] nxt_seqa_pos;
  reg [2:0] nxt_seqb_pos;
  always @* begin
    nxt_seqa_pos = seqa_pos_ff;
    if (!seqa_on || seqa_past || rsta || seqa_brk) begin
      nxt_seqa_pos = 3'h0;
    end else if (seqa_hit) begin
      nxt_seqa_pos = seqa_pos_ff + 3'h1;
    end
    nxt_seqb_pos = seqb_pos_ff;
    if (!seqb_on || seqb_past || rstb || seqb_brk) begin
      nxt_seqb_pos = 3'h0;
    end else if (seqb_hit) begin
      nxt_seqb_pos = seqb_pos_ff + 3'h1;
    end
  end

  // ---------------- Break events and interrupt ----------------
  wire [NCH-1:0] direct_brk = ch_match & ctrl_ff[`CTRL_DIRECT_LSB +: NCH];
  wire [`ST_W-1:0] events = {seqb_brk, seqa_brk, direct_brk};
  wire st_wr = wr_go && (i_avs_address == `REG_STATUS);
  wire [`ST_W-1:0] st_clr = st_wr ? (i_avs_writedata[`ST_W-1:0] & {`ST_W{i_avs_byteenable[0]}})
                                  : {`ST_W{1'b0}};
  // A new event in the clearing cycle keeps its bit set
  wire [`ST_W-1:0] nxt_status = (status_ff & ~st_clr) | events;
  assign o_irq = |(status_ff & mask_ff);
  assign o_break_req = break_ff;

  // ---------------- Read mux ----------------
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    if (a_ch) begin
      case (a_fld)
        `CH_ADDR: nxt_rdata[AW-1:0] = ch_addr_ff[a_chn];
        `CH_DATA: nxt_rdata[DW-1:0] = ch_data_ff[a_chn];
        `CH_COND: nxt_rdata[`COND_W-1:0] = ch_cond_ff[a_chn];
        default: nxt_rdata = 32'h00000000;
      endcase
    end else begin
      case (i_avs_address)
        `REG_CTRL: nxt_rdata[`CTRL_W-1:0] = ctrl_ff;
        `REG_COUNT: nxt_rdata = {cnt_ff, cnt_target_ff};
        `REG_RST_ADDR: nxt_rdata[AW-1:0] = rst_addr_ff;
        `REG_SEQA_CFG: nxt_rdata[`SEQ_CFG_W-1:0] = seqa_cfg_ff;
        `REG_SEQA_STAT: nxt_rdata = seq_stat(seqa_num, seqa_pos_ff);
        `REG_SEQB_CFG: nxt_rdata[`SEQ_CFG_W-1:0] = seqb_cfg_ff;
        `REG_SEQB_STAT: nxt_rdata = seq_stat(seqb_num, seqb_pos_ff);
        `REG_STATUS: nxt_rdata[`ST_W-1:0] = status_ff;
        `REG_MASK: nxt_rdata[`ST_W-1:0] = mask_ff;
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------- Sequential state ----------------
  integer i;
  always @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      ctrl_ff <= `RST_CTRL;
      cnt_target_ff <= {`CNT_W{1'b0}};
      cnt_ff <= {`CNT_W{1'b0}};
      rst_addr_ff <= {AW{1'b0}};
      seqa_cfg_ff <= `RST_SEQ;
      seqb_cfg_ff <= `RST_SEQ;
      seqa_pos_ff <= 3'h0;
      seqb_pos_ff <= 3'h0;
      status_ff <= {`ST_W{1'b0}};
      mask_ff <= `RST_MASK;
      break_ff <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        ch_addr_ff[i] <= {AW{1'b0}};
        ch_data_ff[i] <= {DW{1'b0}};
        ch_cond_ff[i] <= `RST_COND;
      end
    end else begin
      ack_ff <= req && !ack_ff;
      if (i_avs_read && !ack_ff) begin
        rdata_ff <= nxt_rdata;
      end
      cnt_ff <= nxt_cnt;
      seqa_pos_ff <= nxt_seqa_pos;
      seqb_pos_ff <= nxt_seqb_pos;
      status_ff <= nxt_status;
      break_ff <= |events;
      if (wr_go) begin
        if (a_ch) begin
          case (a_fld)
            `CH_ADDR: ch_addr_ff[a_chn] <= merge_be(ch_addr_ff[a_chn], i_avs_writedata,
                                                     i_avs_byteenable);
            `CH_DATA: ch_data_ff[a_chn] <= merge_be(ch_data_ff[a_chn], i_avs_writedata,
                                                     i_avs_byteenable);
            `CH_COND: begin
              if (i_avs_byteenable[0]) begin
                ch_cond_ff[a_chn] <= i_avs_writedata[`COND_W-1:0];
              end
            end
            default: ;
          endcase
        end else begin
          case (i_avs_address)
            `REG_CTRL: ctrl_ff <= ctrl_wr[`CTRL_W-1:0];
            `REG_COUNT: cnt_target_ff <= cnt_wr[`CNT_W-1:0];
            `REG_RST_ADDR: rst_addr_ff <= merge_be(rst_addr_ff, i_avs_writedata,
                                                   i_avs_byteenable);
            `REG_SEQA_CFG: seqa_cfg_ff <= seqa_wr[`SEQ_CFG_W-1:0];
            `REG_SEQB_CFG: seqb_cfg_ff <= seqb_wr[`SEQ_CFG_W-1:0];
            `REG_MASK: begin
              if (i_avs_byteenable[0]) begin
                mask_ff <= i_avs_writedata[`ST_W-1:0];
              end
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule // bus_break_comparator_sequencer

// File: cpu_bus_model.sv
// Processor bus model feeding bus and retire cycles into the break unit
module cpu_bus_model (
  input wire logic i_ref_clk,
  output logic o_valid,
  output logic [31:0] o_addr,
  output logic [31:0] o_data,
  output logic o_read,
  output logic [1:0] o_type,
  output logic o_retire_valid,
  output logic [31:0] o_retire_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_addr = 32'h0;
    o_data = 32'h0;
    o_read = 1'b0;
    o_type = 2'h0;
    o_retire_valid = 1'b0;
    o_retire_pc = 32'h0;
  end
  // Released lines show inverted values so a stale bus cannot fake a match
  task automatic cyc(input logic v, input logic rv, input logic [31:0] a,
                     input logic [31:0] d, input logic rd, input logic [1:0] t);
    @(posedge i_ref_clk);
    o_valid <= v;
    o_retire_valid <= rv;
    o_addr <= v ? a : ~o_addr;
    o_data <= v ? d : ~o_data;
    o_read <= v ? rd : ~o_read;
    o_type <= v ? t : ~o_type;
    o_retire_pc <= rv ? a : ~o_retire_pc;
  endtask
  task automatic idle;
    cyc(1'b0, 1'b0, 32'h0, 32'h0, 1'b0, 2'h0);
  endtask
endmodule // cpu_bus_model

// File: testbench.sv
// Self-checking bench for the bus break unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_reset_n, i_avs_read, i_avs_write;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata;
  wire [31:0] o_avs_readdata, bus_addr, bus_data, retire_pc;
  wire o_avs_waitrequest, bus_valid, bus_read, retire_valid, o_break_req, o_irq;
  wire [1:0] bus_type;
  int n_errors = 0;
  int cmp_count = 0;
  int brk = 0;
  int exp_brk = 0;

  bus_break_comparator_sequencer DUT (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_bus_valid(bus_valid), .i_bus_addr(bus_addr),
    .i_bus_data(bus_data), .i_bus_read(bus_read), .i_bus_type(bus_type),
    .i_retire_valid(retire_valid), .i_retire_pc(retire_pc), .o_break_req(o_break_req),
    .o_irq(o_irq));
  cpu_bus_model cpu (
    .i_ref_clk(i_ref_clk), .o_valid(bus_valid), .o_addr(bus_addr), .o_data(bus_data),
    .o_read(bus_read), .o_type(bus_type), .o_retire_valid(retire_valid),
    .o_retire_pc(retire_pc));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) if (o_break_req === 1'b1) brk <= brk + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_ref_clk);
    i_avs_write <= w;
    i_avs_read <= ~w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    // Waitrequest is sampled at the rising edge; a hang is left to the watchdog
    @(posedge i_ref_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Counted break pulses settle one rising edge after the bus goes idle
  task automatic bchk(input int add);
    exp_brk += add;
    repeat (3) @(negedge i_ref_clk);
    chk(32'(brk), 32'(exp_brk));
  endtask
  task automatic ichk(input logic e);
    @(negedge i_ref_clk);
    chk({31'h0, o_irq}, {31'h0, e});
  endtask
  task automatic hit(input logic [31:0] a);
    cpu.cyc(1'b1, 1'b0, a, 32'h0, 1'b1, 2'h1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    i_reset_n = 1'b0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 8'h00;
    i_avs_writedata = 32'h0;
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    wr(8'h7c, 32'hffffffff);
    rchk(8'h7c, 32'h0);
    rchk(8'h70, 32'h0);
    $display("test reset done");
    wr(8'h10, 32'h100);
    wr(8'h14, 32'h55);
    wr(8'h18, 32'h7d);
    wr(8'h74, 32'h3f);
    wr(8'h00, 32'h1);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h56, 1'b1, 2'h1);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h55, 1'b0, 2'h1);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h55, 1'b1, 2'h2);
    cpu.cyc(1'b1, 1'b0, 32'h104, 32'h55, 1'b1, 2'h1);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h55, 1'b1, 2'h1);
    cpu.idle();
    bchk(1);
    rchk(8'h70, 32'h1);
    ichk(1'b1);
    wr(8'h70, 32'h1);
    ichk(1'b0);
    $display("test all terms done");
    for (int t = 0; t < 4; t++) begin
      wr(8'h18, 32'h21 | 32'(t << 6));
      for (int b = 0; b < 3; b++) cpu.cyc(1'b1, 1'b0, 32'h100, 32'h0, 1'b1, 2'(b));
      cpu.idle();
      bchk(t == 3 ? 3 : 1);
    end
    $display("test access types done");
    wr(8'h18, 32'h02);
    hit(32'h100);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h0, 1'b1, 2'h0);
    cpu.idle();
    bchk(1);
    wr(8'h18, 32'h03);
    cpu.cyc(1'b1, 1'b0, 32'h100, 32'h0, 1'b1, 2'h0);
    cpu.idle();
    bchk(0);
    cpu.cyc(1'b0, 1'b1, 32'h104, 32'h0, 1'b1, 2'h0);
    cpu.cyc(1'b0, 1'b1, 32'h100, 32'h0, 1'b1, 2'h0);
    cpu.idle();
    bchk(1);
    $display("test program counter done");
    wr(8'h18, 32'h01);
    wr(8'h50, 32'h3);
    repeat (2) hit(32'h100);
    cpu.idle();
    bchk(0);
    rchk(8'h50, 32'h00020003);
    hit(32'h100);
    cpu.idle();
    bchk(1);
    rchk(8'h50, 32'h3);
    wr(8'h50, 32'h0);
    $display("test count done");
    wr(8'h70, 32'h3f);
    wr(8'h00, 32'h50);
    for (int c = 1; c < 4; c++) begin
      wr(8'(16 * (c + 1)), 32'h100 + 32'(16 * c));
      wr(8'(16 * (c + 1) + 8), 32'h1);
    end
    wr(8'h54, 32'h400);
    wr(8'h60, 32'h393);
    hit(32'h120);
    cpu.idle();
    rchk(8'h64, 32'h30);
    hit(32'h110);
    cpu.idle();
    rchk(8'h64, 32'h31);
    hit(32'h400);
    cpu.idle();
    bchk(0);
    rchk(8'h64, 32'h30);
    hit(32'h110);
    hit(32'h120);
    hit(32'h130);
    cpu.idle();
    bchk(1);
    rchk(8'h70, 32'h10);
    rchk(8'h64, 32'h30);
    $display("test set A done");
    wr(8'h00, 32'h20);
    wr(8'h68, 32'h15557);
    repeat (6) hit(32'h110);
    cpu.idle();
    rchk(8'h6c, 32'h76);
    hit(32'h110);
    cpu.idle();
    bchk(1);
    rchk(8'h70, 32'h30);
    wr(8'h74, 32'h0);
    ichk(1'b0);
    wr(8'h74, 32'h3f);
    ichk(1'b1);
    wr(8'h70, 32'h30);
    ichk(1'b0);
    $display("test set B done");
    tally_and_finish();
  end
endmodule // testbench
